// *** core/vac_pkg.sv ***
// constants, register map and types of the valve actuator end position control
// assumes a 25 MHz system clock and a 32-bit classic wishbone register bus
package vac_pkg;
  // clock and time base
  localparam int unsigned CLK_HZ          = 25_000_000;
  localparam int unsigned SEC_CYCLES      = CLK_HZ;
  localparam int unsigned TQ_CLEAR_MS     = 500;
  localparam int unsigned TQ_CLEAR_CYCLES = (CLK_HZ / 1000) * TQ_CLEAR_MS;
  localparam logic [1:0]  INIT_CYCLES     = 2'h3;

  // register byte offsets
  localparam logic [7:0] A_CMD       = 8'h00;
  localparam logic [7:0] A_CFG       = 8'h04;
  localparam logic [7:0] A_RUN_LIMIT = 8'h08;
  localparam logic [7:0] A_START_MON = 8'h0C;
  localparam logic [7:0] A_STATUS    = 8'h10;
  localparam logic [7:0] A_IRQ_STAT  = 8'h14;
  localparam logic [7:0] A_IRQ_MASK  = 8'h18;

  // command register bits
  localparam int CMD_CLOSE  = 0;
  localparam int CMD_OFF    = 1;
  localparam int CMD_OPEN   = 2;
  localparam int CMD_FRESET = 6;
  localparam int CMD_AUX    = 12;
  localparam int CMD_RELAY  = 15;

  // configuration register bits
  localparam int CFG_VAR_LSB  = 0;
  localparam int CFG_RELAY_FO = 2;
  localparam int CFG_AUX_FO   = 3;

  // interrupt status bits
  localparam int IRQ_TQ_FAULT  = 0;
  localparam int IRQ_RUN_FAULT = 1;
  localparam int IRQ_ST_FAULT  = 2;
  localparam int IRQ_END_POS   = 3;
  localparam int IRQ_W         = 4;

  // reset values and special settings
  localparam logic [15:0] RUN_LIMIT_RST = 16'h0001;
  localparam logic [15:0] RUN_DISABLE   = 16'h0001;
  localparam logic [15:0] START_MON_RST = 16'h0003;
  localparam logic [7:0]  CFG_RST       = 8'h00;

  // actuator variants as held in the configuration field
  localparam logic [1:0] VAR_1 = 2'h0;
  localparam logic [1:0] VAR_2 = 2'h1;
  localparam logic [1:0] VAR_3 = 2'h2;
  localparam logic [1:0] VAR_4 = 2'h3;

  typedef enum logic [1:0] {MV_STOP, MV_OPEN, MV_CLOSE} vac_motion_e;
endpackage : vac_pkg

// *** core/vac_tmr_if.sv ***
// bundle between the control logic and one supervision timer
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface vac_tmr_if #(parameter int W = 16);
  logic         start;
  logic         stop;
  logic         step;
  logic [W-1:0] limit;
  logic         expired;
  logic         running;
  modport ctl (output start, stop, step, limit, input expired, running);
  modport tmr (input start, stop, step, limit, output expired, running);
endinterface : vac_tmr_if

// *** core/vac_sync.sv ***
// two flip-flop synchroniser for a group of pin inputs
// assumes inputs are asynchronous to clk_i
`timescale 1ns/1ps
module vac_sync #(parameter int W = 4) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // pins in, synchronised out
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta <= '0;
      q_o  <= '0;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule : vac_sync

// *** core/vac_timer.sv ***
// supervision timer: counts step pulses from start until the limit is reached
// assumes start has priority over stop in the same cycle
`timescale 1ns/1ps
module vac_timer #(parameter int W = 16) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // control bundle
  vac_tmr_if.tmr    t
);
  logic [W-1:0] cnt;
  logic         run;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run <= 1'b0;
      cnt <= '0;
    end else if (t.start) begin
      run <= 1'b1;
      cnt <= '0;
    end else if (t.stop) begin
      run <= 1'b0;
      cnt <= '0;
    end else if (run && t.step && cnt != t.limit) begin
      cnt <= cnt + 1'b1;
    end
  end

  assign t.running = run;
  assign t.expired = run && (cnt == t.limit);
endmodule : vac_timer

// *** core/vac_valve_ctl.sv ***
// open/close valve actuator end position control with wishbone registers
// assumes limit and torque pins asynchronous; contactor outputs drive relays
`timescale 1ns/1ps
module vac_valve_ctl
  import vac_pkg::*;
#(
  parameter int unsigned TQ_CLEAR_CYC = TQ_CLEAR_CYCLES,
  parameter int unsigned SEC_CYC      = SEC_CYCLES
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // actuator pins
  input  wire logic        open_limit_input_i,
  input  wire logic        closed_limit_input_i,
  input  wire logic        spare_fault_input_i,
  input  wire logic        torque_chain_input_i,
  output logic             open_contactor_o,
  output logic             close_contactor_o,
  output logic             aux_relay_output_o,
  output logic             aux_supply_output_o,
  // interrupt
  output logic             irq_o
);
  logic [3:0]         pins_s;
  logic               lim_o;
  logic               lim_c;
  logic               spare_s;
  logic               tq_ev;
  logic [1:0]         variant;
  logic               relay_fo;
  logic               aux_fo;
  logic               relay_cmd;
  logic               aux_cmd;
  logic [15:0]        run_limit;
  logic [15:0]        start_mon;
  logic [IRQ_W-1:0]   irq_stat;
  logic [IRQ_W-1:0]   irq_mask;
  vac_motion_e        motion;
  vac_motion_e        next_motion;
  logic               arm;
  logic               blk_open;
  logic               blk_close;
  logic               tq_open;
  logic               tq_closed;
  logic               f_torque;
  logic               f_run;
  logic               f_start;
  logic               fault;
  logic [1:0]         init_cnt;
  logic               init_done;
  logic               pwr_chk;
  logic [24:0]        sec_cnt;
  logic               sec_tick;
  logic               wr;
  logic               cmd_wr;
  logic               cmd_open;
  logic               cmd_close;
  logic               cmd_off;
  logic               cmd_freset;
  logic               moving;
  logic               dir_open;
  logic               lim_here;
  logic               src_lim;
  logic               lim_direct;
  logic               tq_bad;
  logic               start_open;
  logic               start_close;
  logic               stop_now;
  logic               stop_blk;
  logic               ft;
  logic               fr;
  logic               fs;
  logic               endev;
  logic               arm_set;
  logic [31:0]        status;

  vac_tmr_if #(.W(24)) tq_if ();
  vac_tmr_if #(.W(16)) run_if ();
  vac_tmr_if #(.W(16)) st_if ();

  vac_sync #(.W(4)) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({spare_fault_input_i, ~torque_chain_input_i,
             closed_limit_input_i, open_limit_input_i}),
    .q_o   (pins_s)
  );

  vac_timer #(.W(24)) u_tq_tmr  (.clk_i(clk_i), .rst_i(rst_i), .t(tq_if.tmr));
  vac_timer #(.W(16)) u_run_tmr (.clk_i(clk_i), .rst_i(rst_i), .t(run_if.tmr));
  vac_timer #(.W(16)) u_st_tmr  (.clk_i(clk_i), .rst_i(rst_i), .t(st_if.tmr));

  // input polarity, torque inverted ahead of sync
  assign lim_o   = pins_s[0];
  assign lim_c   = pins_s[1];
  assign tq_ev   = pins_s[2];
  assign spare_s = pins_s[3];
  assign fault   = f_torque | f_run | f_start;

  // power-up settling of the synchronisers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      init_cnt <= 2'h0;
    end else if (init_cnt != INIT_CYCLES) begin
      init_cnt <= init_cnt + 2'h1;
    end
  end
  assign init_done = (init_cnt == INIT_CYCLES);
  assign pwr_chk   = (init_cnt == INIT_CYCLES - 2'h1);

  // one second time base
  always_ff @(posedge clk_i) begin
    if (rst_i || sec_tick) begin
      sec_cnt <= 25'h000_0000;
    end else begin
      sec_cnt <= sec_cnt + 25'h000_0001;
    end
  end
  assign sec_tick = (sec_cnt == SEC_CYC[24:0] - 25'h000_0001);

  // bus strobes: writes commit at the edge that ends the ack cycle
  assign wr         = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  assign cmd_wr     = wr && (wb_adr_i == A_CMD) && wb_sel_i[0];
  assign cmd_open   = cmd_wr && wb_dat_i[CMD_OPEN];
  assign cmd_close  = cmd_wr && wb_dat_i[CMD_CLOSE];
  assign cmd_off    = cmd_wr && wb_dat_i[CMD_OFF];
  assign cmd_freset = cmd_wr && wb_dat_i[CMD_FRESET];

  // decisions, only travel between end positions
  assign moving   = (motion != MV_STOP);
  assign dir_open = (motion == MV_OPEN);
  assign lim_here = dir_open ? lim_o : lim_c;
  assign src_lim  = dir_open ? lim_c : lim_o;
  assign lim_direct = dir_open ? (variant == VAR_1 || variant == VAR_3)
                               : (variant == VAR_1 || variant == VAR_4);
  // torque ignored during the clearing window, fault when it stays
  assign tq_bad = tq_ev && (!tq_if.running || tq_if.expired);
  // blocked direction and fault inhibit starts
  assign start_open  = cmd_open && !cmd_off && !cmd_close && motion == MV_STOP &&
                       !fault && !blk_open && init_done;
  assign start_close = cmd_close && !cmd_off && !cmd_open && motion == MV_STOP &&
                       !fault && !blk_close && init_done;

  always_comb begin
    stop_now = 1'b0;
    stop_blk = 1'b0;
    ft       = 1'b0;
    fr       = 1'b0;
    fs       = 1'b0;
    endev    = 1'b0;
    arm_set  = 1'b0;
    if (moving) begin
      if (tq_bad) begin
        stop_now = 1'b1;
        stop_blk = 1'b1;
        ft       = !arm || tq_if.running;
        endev    = arm && !tq_if.running;
      end else if (lim_here) begin
        if (lim_direct) begin
          stop_now = 1'b1;
          stop_blk = 1'b1;
          endev    = 1'b1;
        end else begin
          arm_set = 1'b1;
        end
      end else if (st_if.expired && src_lim) begin
        stop_now = 1'b1;
        fs       = 1'b1;
      end else if (run_if.expired && run_limit != RUN_DISABLE) begin
        stop_now = 1'b1;
        fr       = 1'b1;
      end
    end
  end

  always_comb begin
    next_motion = motion;
    if (cmd_off || stop_now) begin
      next_motion = MV_STOP;
    end else if (start_open) begin
      next_motion = MV_OPEN;
    end else if (start_close) begin
      next_motion = MV_CLOSE;
    end
  end

  // timer control
  assign tq_if.start  = (start_open || start_close) && tq_ev;
  assign tq_if.stop   = !tq_ev || !moving;
  assign tq_if.step   = 1'b1;
  assign tq_if.limit  = TQ_CLEAR_CYC[23:0];
  assign run_if.start = start_open || start_close;
  assign run_if.stop  = !moving;
  assign run_if.step  = sec_tick;
  assign run_if.limit = run_limit;
  assign st_if.start  = (start_open && lim_c) || (start_close && lim_o);
  assign st_if.stop   = !moving || !src_lim;
  assign st_if.step   = sec_tick;
  assign st_if.limit  = start_mon;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      motion            <= MV_STOP;
      open_contactor_o  <= 1'b0;
      close_contactor_o <= 1'b0;
    end else begin
      motion            <= next_motion;
      open_contactor_o  <= (next_motion == MV_OPEN);
      close_contactor_o <= (next_motion == MV_CLOSE);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      blk_open  <= 1'b0;
      blk_close <= 1'b0;
      arm       <= 1'b0;
    end else begin
      if (start_open || start_close) begin
        blk_open  <= 1'b0;
        blk_close <= 1'b0;
      end else if (stop_now && stop_blk) begin
        blk_open  <= dir_open;
        blk_close <= !dir_open;
      end else if (pwr_chk && tq_ev && !lim_o && !lim_c) begin
        blk_close <= 1'b1;
      end
      if (next_motion == MV_STOP || start_open || start_close) begin
        arm <= 1'b0;
      end else if (arm_set) begin
        arm <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tq_open   <= 1'b0;
      tq_closed <= 1'b0;
    end else if (!tq_ev) begin
      tq_open   <= 1'b0;
      tq_closed <= 1'b0;
    end else if (moving && tq_bad) begin
      tq_open   <= dir_open;
      tq_closed <= !dir_open;
    end else if (pwr_chk && !lim_o && !lim_c) begin
      tq_closed <= 1'b1;
    end
  end

  // faults: a new fault wins over a reset in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      f_torque <= 1'b0;
      f_run    <= 1'b0;
      f_start  <= 1'b0;
    end else begin
      f_torque <= ft || (pwr_chk && tq_ev && !lim_o && !lim_c) ||
                  (f_torque && !cmd_freset);
      f_run    <= fr || (f_run && !cmd_freset);
      f_start  <= fs || (f_start && !cmd_freset);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      aux_relay_output_o  <= 1'b0;
      aux_supply_output_o <= 1'b0;
    end else begin
      aux_relay_output_o  <= relay_fo ? fault : relay_cmd;
      aux_supply_output_o <= aux_fo ? fault : aux_cmd;
    end
  end

  // configuration registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      variant   <= CFG_RST[1:0];
      relay_fo  <= CFG_RST[CFG_RELAY_FO];
      aux_fo    <= CFG_RST[CFG_AUX_FO];
      relay_cmd <= 1'b0;
      aux_cmd   <= 1'b0;
      run_limit <= RUN_LIMIT_RST;
      start_mon <= START_MON_RST;
    end else if (wr) begin
      if (wb_adr_i == A_CMD && wb_sel_i[1]) begin
        relay_cmd <= wb_dat_i[CMD_RELAY];
        aux_cmd   <= wb_dat_i[CMD_AUX];
      end
      if (wb_adr_i == A_CFG && wb_sel_i[0]) begin
        variant  <= wb_dat_i[CFG_VAR_LSB +: 2];
        relay_fo <= wb_dat_i[CFG_RELAY_FO];
        aux_fo   <= wb_dat_i[CFG_AUX_FO];
      end
      if (wb_adr_i == A_RUN_LIMIT) begin
        if (wb_sel_i[0]) run_limit[7:0]  <= wb_dat_i[7:0];
        if (wb_sel_i[1]) run_limit[15:8] <= wb_dat_i[15:8];
      end
      if (wb_adr_i == A_START_MON) begin
        if (wb_sel_i[0]) start_mon[7:0]  <= wb_dat_i[7:0];
        if (wb_sel_i[1]) start_mon[15:8] <= wb_dat_i[15:8];
      end
    end
  end

  // sticky events, write one to clear, set wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat <= '0;
      irq_mask <= '0;
      irq_o    <= 1'b0;
    end else begin
      irq_stat <= ({endev, fs, fr, ft} |
                   (irq_stat & ~((wr && wb_adr_i == A_IRQ_STAT && wb_sel_i[0]) ?
                                 wb_dat_i[IRQ_W-1:0] : {IRQ_W{1'b0}})));
      if (wr && wb_adr_i == A_IRQ_MASK && wb_sel_i[0]) begin
        irq_mask <= wb_dat_i[IRQ_W-1:0];
      end
      irq_o <= |(irq_stat & irq_mask);
    end
  end

  assign status = {16'h0000, f_start, f_run, f_torque, tq_ev, spare_s, lim_c, lim_o, arm,
                   blk_close, blk_open, tq_closed, tq_open, fault,
                   (motion == MV_OPEN), (motion == MV_STOP), (motion == MV_CLOSE)};

  // wishbone answer, one wait state, ack for one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      unique case (wb_adr_i)
        A_CMD:       wb_dat_o <= {16'h0000, relay_cmd, 2'b00, aux_cmd, 12'h000};
        A_CFG:       wb_dat_o <= {28'h000_0000, aux_fo, relay_fo, variant};
        A_RUN_LIMIT: wb_dat_o <= {16'h0000, run_limit};
        A_START_MON: wb_dat_o <= {16'h0000, start_mon};
        A_STATUS:    wb_dat_o <= status;
        A_IRQ_STAT:  wb_dat_o <= {28'h000_0000, irq_stat};
        A_IRQ_MASK:  wb_dat_o <= {28'h000_0000, irq_mask};
        default:     wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_torque_hit;
    moving && tq_ev && !tq_if.running;
  endsequence
  sequence s_stop_blk_open;
    motion == MV_STOP && blk_open;
  endsequence

  property p_v1_open_limit;
    variant == VAR_1 && motion == MV_OPEN && lim_o |=> s_stop_blk_open;
  endproperty
  a_v1_open_limit: assert property (p_v1_open_limit)
    else $error("open limit did not stop variant one");
  property p_v1_torque;
    (variant == VAR_1) and s_torque_hit |=> f_torque && motion == MV_STOP;
  endproperty
  a_v1_torque: assert property (p_v1_torque)
    else $error("torque in variant one did not fault");
  property p_v2_armed;
    (variant == VAR_2 && motion == MV_CLOSE && arm) and s_torque_hit
      |=> motion == MV_STOP && blk_close && irq_stat[IRQ_END_POS];
  endproperty
  a_v2_armed: assert property (p_v2_armed)
    else $error("armed torque stop missing");
  property p_unarmed;
    (!arm) and s_torque_hit |=> f_torque ##1 !open_contactor_o && !close_contactor_o;
  endproperty
  a_unarmed: assert property (p_unarmed)
    else $error("unarmed torque did not fault");
  property p_v4_close_tq;
    (variant == VAR_4 && motion == MV_CLOSE) and s_torque_hit |=> f_torque;
  endproperty
  a_v4_close_tq: assert property (p_v4_close_tq)
    else $error("closing torque in variant four did not fault");
  property p_tq_closed;
    (motion == MV_CLOSE) and s_torque_hit |=> tq_closed && !tq_open;
  endproperty
  a_tq_closed: assert property (p_tq_closed)
    else $error("torque closed indication missing");
  property p_powerup;
    pwr_chk && tq_ev && !lim_o && !lim_c |=> f_torque && blk_close && tq_closed;
  endproperty
  a_powerup: assert property (p_powerup)
    else $error("power-up torque not treated as closing");
  property p_blocked;
    blk_open && motion == MV_STOP |=> motion != MV_OPEN;
  endproperty
  a_blocked: assert property (p_blocked)
    else $error("start in blocked direction");
  property p_tq_window;
    moving && tq_ev && tq_if.expired |=> f_torque && motion == MV_STOP;
  endproperty
  a_tq_window: assert property (p_tq_window)
    else $error("torque not cleared in time without fault");
  property p_run_off;
    run_limit == RUN_DISABLE |=> !$rose(f_run);
  endproperty
  a_run_off: assert property (p_run_off)
    else $error("run time fault while disabled");
  property p_start_mon;
    fs |=> f_start && motion == MV_STOP ##1 !open_contactor_o && !close_contactor_o;
  endproperty
  a_start_mon: assert property (p_start_mon)
    else $error("limit release fault did not stop");
  property p_fault_out;
    relay_fo |=> aux_relay_output_o == $past(fault);
  endproperty
  a_fault_out: assert property (p_fault_out)
    else $error("relay fault output wrong");
  property p_reset_idle;
    !init_done |-> !open_contactor_o && !close_contactor_o && !blk_open && !blk_close;
  endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("contactor or block active after reset");
endmodule : vac_valve_ctl

// *** bench/vac_act_model.sv ***
// actuator model: travel, limit switches, series torque chain
// assumes contactor levels from the controller on the same clock
`timescale 1ns/1ps
module vac_act_model (
  // clock and drive
  input  wire logic clk_i,
  input  wire logic open_i,
  input  wire logic close_i,
  input  wire logic jam_i,
  // switch contacts
  output logic      olim_o,
  output logic      clim_o,
  output logic      tq_o,
  output logic      mid_o
);
  int   pos = 5;
  logic ph  = 1'b0;
  always @(posedge clk_i) begin
    ph <= !ph;
    if (ph && open_i && pos < 100) pos <= pos + 1;
    if (ph && close_i && pos > 0) pos <= pos - 1;
  end
  assign olim_o = pos >= 90;
  assign clim_o = pos <= 10;
  assign tq_o   = !(jam_i || pos >= 100 || pos <= 0);
  assign mid_o  = pos < 100;
endmodule : vac_act_model

// *** bench/tb.sv ***
// self-checking bench of the valve actuator control
// assumes the package and the actuator model are compiled first
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
  $display("ERROR %s exp %h got %h", n, e, g); end end
module tb import vac_pkg::*; ;
  typedef struct {string n; logic [36:0] m; logic [36:0] e;} vac_note_s;
  localparam logic [36:0] ST = 37'h0f_0000_00ff;
  localparam logic [36:0] IQ = 37'h10_0000_000f;
  localparam logic [7:0]  RA [5] = '{A_CFG, A_RUN_LIMIT, A_START_MON, A_IRQ_MASK, 8'h1c};
  localparam logic [36:0] RE [5] = '{37'h0, 37'h1, 37'h3, 37'h0, 37'h0};
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc   = 1'b0;
  logic        stb   = 1'b0;
  logic        we    = 1'b0;
  logic        jam   = 1'b0;
  logic [7:0]  adr   = 8'h00;
  logic [31:0] dat   = 32'h0000_0000;
  logic [31:0] rs    = 32'haee5;
  logic [31:0] rdat;
  logic        ack, opn, cls, rly, sup, irq, olim, clim, tq, mid;
  int          bad_count = 0;
  int          tests_run = 0;
  vac_note_s   notes[$];

  always #20 clk_i = ~clk_i;

  vac_valve_ctl #(.TQ_CLEAR_CYC(20), .SEC_CYC(20)) vac_valve_ctl_inst (
    .clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_dat_i(dat), .wb_sel_i(4'hf), .wb_dat_o(rdat), .wb_ack_o(ack),
    .open_limit_input_i(olim), .closed_limit_input_i(clim), .spare_fault_input_i(mid),
    .torque_chain_input_i(tq), .open_contactor_o(opn), .close_contactor_o(cls),
    .aux_relay_output_o(rly), .aux_supply_output_o(sup), .irq_o(irq));
  vac_act_model vac_act_model_inst (
    .clk_i, .open_i(opn), .close_i(cls), .jam_i(jam), .olim_o(olim), .clim_o(clim),
    .tq_o(tq), .mid_o(mid));

  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction : rnd

  // one classic cycle, held until ack is sampled
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    {cyc, stb} <= 2'b00;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rd(input string n, input logic [7:0] a, input logic [36:0] m,
                    input logic [36:0] e);
    notes.push_back('{n, m, e});
    bus(1'b0, a, 32'h0000_0000);
  endtask : rd

  task automatic idle();
    int k = 0;
    do @(posedge clk_i); while ((opn | cls) !== 1'b0 && k++ < 600);
    if (k > 600) bad_count++;
  endtask : idle

  // read results with output pins, checked at the ack edge
  always @(posedge clk_i) begin
    if (ack === 1'b1 && we === 1'b0) begin
      if (notes.size() == 0) `CHK("queue", 1'b1, 1'b0)
      else begin
        `CHK(notes[0].n, notes[0].e, {irq, rly, sup, cls, opn, rdat} & notes[0].m)
        void'(notes.pop_front());
      end
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize

  initial begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    summarize();
  end

  initial begin
    logic ao;
    logic ac;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    rd("idle", A_STATUS, ST | IQ | 37'h1e00, 37'h0c02);
    wr(8'h1c, rnd());
    foreach (RA[i]) rd("reset value", RA[i], 37'hffff_ffff, RE[i]);
    wr(A_IRQ_MASK, 32'h1);
    $display("reset test done");
    for (int i = 0; i < 4; i++) begin
      ao = (i == 1 || i == 3);
      ac = (i == 1 || i == 2);
      wr(A_CFG, i);
      wr(A_IRQ_STAT, 32'hf);
      wr(A_CMD, 32'h4);
      idle();
      rd("open end", A_STATUS, ST, 37'h42 | {ao, 4'h0});
      rd("end irq", A_IRQ_STAT, IQ, 37'h8);
      wr(A_CMD, 32'h4);
      rd("reopen", A_STATUS, 37'h01_0000_0004, 37'h0);
      wr(A_CMD, 32'h1);
      repeat (60 + rnd() % 8) @(posedge clk_i);
      jam <= 1'b1;
      idle();
      rd("jam", A_STATUS, ST, 37'haa);
      rd("jam irq", A_IRQ_STAT, 37'h10_0000_0001, 37'h10_0000_0001);
      wr(A_IRQ_STAT, 32'h1);
      rd("irq clear", A_IRQ_STAT, 37'h10_0000_0001, 37'h0);
      wr(A_CMD, 32'h40);
      wr(A_CMD, 32'h1);
      rd("blocked", A_STATUS, 37'h02_0000_0009, 37'h0);
      wr(A_CMD, 32'h4);
      idle();
      rd("refault", A_STATUS, ST, 37'h5a);
      jam <= 1'b0;
      wr(A_CMD, 32'h40);
      wr(A_CMD, 32'h1);
      idle();
      rd("closed end", A_STATUS, ST, 37'h82 | {ac, 5'h0});
      $display("variant %0d done", i);
    end
    wr(A_RUN_LIMIT, 32'h2);
    wr(A_CMD, 32'h4);
    idle();
    rd("run limit", A_IRQ_STAT, 37'h2, 37'h2);
    wr(A_CFG, 32'hc);
    rd("fault out", A_STATUS, 37'h0c_0000_0008, 37'h0c_0000_0008);
    wr(A_CFG, 32'h0);
    wr(A_CMD, 32'h1000);
    rd("cmd out", A_CMD, 37'h0c_0000_9000, 37'h04_0000_1000);
    $display("run limit and outputs done");
    jam <= 1'b1;
    rst_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    rd("power up", A_STATUS, 37'hf8, 37'ha8);
    wr(A_CMD, 32'h40);
    wr(A_CMD, 32'h1);
    rd("pu close", A_STATUS, 37'h02_0000_0000, 37'h0);
    wr(A_CMD, 32'h4);
    rd("pu open", A_STATUS, 37'h01_0000_0000, 37'h01_0000_0000);
    $display("power-up test done");
    summarize();
  end
endmodule : tb
